// [design/qdc_ctrl.v]
/*
 * quad 8-bit converter serial control: three-wire serial port, per-channel
 * input and converter registers, async update, open-drain power-fail flag.
 * assumes all pins come from outside core_clk and are synchronised here;
 * the serial clock is sampled and its edges found in the core domain.
 */
// Summary of operation
// - taking async_update_n low updates all four converter outputs with no serial transaction.
// - chip select is active low and the serial port only responds while it is low.
// - serial_in data bytes are shifted in least significant bit first on the serial clock.
// - each transaction begins with an instruction of 4, 6 or 7 bits ahead of the data byte.
// - readback data leaves most or least significant bit first as the instruction selects.
// - readback data changes on the rising or falling clock edge as the instruction selects.
// - the power-fail output is pulled low after the supply was interrupted.
// - the power-fail output is open drain, only ever pulled low.
// - one shared shift register feeds the channels; each channel has an 8-bit input register and an 8-bit converter register.
// - a central sequencer moves data between registers and runs the serial exchange.
// - a falling edge on async_update_n while chip select is high copies all input registers into the converter registers.
// - write instruction is start, read/write, global, update, two address bits; update acts on select rise.
// - converter registers clear at power-up and the power-fail flag clears when chip select goes low.
`timescale 1ns/1ps
`include "qdc_regs.vh"

module qdc_ctrl #(
    parameter NUM_CH = 4,
    parameter DATA_W = 8
) (
    input wire core_clk,
    input wire reset,
    input wire serial_clk,
    input wire chip_sel_n,
    input wire serial_in,
    input wire async_update_n,
    output reg serial_out,
    output reg serial_out_oe_n,
    output wire power_fail_n_out,
    output wire power_fail_n_oe_n,
    output reg [NUM_CH*DATA_W-1:0] conv_data
);

    localparam ST_IDLE = 3'h0;
    localparam ST_HDR = 3'h1;
    localparam ST_WDATA = 3'h2;
    localparam ST_RDATA = 3'h3;
    localparam ST_DONE = 3'h4;

    // two-flop synchronisers on every pin
    reg [1:0] sclk_s_r, cs_s_r, din_s_r, au_s_r;
    reg sclk_d_r, cs_d_r, au_d_r;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_s_r <= 2'h0;
            cs_s_r <= 2'h3;
            din_s_r <= 2'h0;
            au_s_r <= 2'h3;
            sclk_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            au_d_r <= 1'b1;
        end else begin
            sclk_s_r <= {sclk_s_r[0], serial_clk};
            cs_s_r <= {cs_s_r[0], chip_sel_n};
            din_s_r <= {din_s_r[0], serial_in};
            au_s_r <= {au_s_r[0], async_update_n};
            sclk_d_r <= sclk_s_r[1];
            cs_d_r <= cs_s_r[1];
            au_d_r <= au_s_r[1];
        end
    end

    // edges are seen three core cycles after the pin moves, so a serial clock
    // half period under one core cycle can slip an edge
    wire cs_low = ~cs_s_r[1];
    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    wire cs_fall = ~cs_s_r[1] & cs_d_r;
    wire cs_rise = cs_s_r[1] & ~cs_d_r;
    wire au_fall = ~au_s_r[1] & au_d_r;

    // per-channel input registers; converter registers sit on conv_data
    reg [DATA_W-1:0] in_reg_r [0:NUM_CH-1];
    reg [2:0] state_r;
    reg [3:0] cnt_r;
    reg [6:0] hdr_r;
    reg [DATA_W-1:0] shift_r;
    reg [1:0] ch_r;
    reg wr_any_r;
    reg pf_r;
    reg out_en_r;
    reg pend_r;

    // instruction decode from the captured header bits
    wire is_rd = hdr_r[`QDC_POS_RDWR];
    wire is_glob = hdr_r[`QDC_POS_GLOBAL];
    wire rf_rise = hdr_r[`QDC_POS_RF];
    wire msb_first = hdr_r[`QDC_POS_ML];
    // the last address bit is still on the synchronised pin when the header
    // completes, so it is taken from there rather than from hdr_r
    wire [1:0] hdr_addr = is_rd ? {hdr_r[5], din_s_r[1]} : {hdr_r[4], din_s_r[1]};
    // a global write ends after the update bit; single writes carry two address
    // bits more and reads one more again
    wire [3:0] hdr_len = (cnt_r >= 4'h2 && hdr_r[`QDC_POS_RDWR]) ? `QDC_RD_HDR_LEN :
        (cnt_r >= 4'h3 && hdr_r[`QDC_POS_GLOBAL]) ? `QDC_GW_HDR_LEN : `QDC_WR_HDR_LEN;
    wire out_edge = rf_rise ? sclk_rise : sclk_fall;
    wire [DATA_W-1:0] rd_word = in_reg_r[ch_r];

    integer i;

    // central sequencer: header capture, data shift, register transfers
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            hdr_r <= 7'h00;
            shift_r <= `QDC_REG_RST;
            ch_r <= 2'h0;
            wr_any_r <= 1'b0;
            pf_r <= `QDC_PF_RST; // power-up after an outage raises the flag
            out_en_r <= 1'b0;
            pend_r <= 1'b0;
            serial_out <= 1'b0;
            conv_data <= {NUM_CH*DATA_W{1'b0}};
            for (i = 0; i < NUM_CH; i = i + 1)
                in_reg_r[i] <= `QDC_REG_RST;
        end else begin
            if (cs_fall)
                pf_r <= 1'b0;
            // async update is refused while selected, the host keeps select high
            if (au_fall && !cs_low) begin
                for (i = 0; i < NUM_CH; i = i + 1)
                    conv_data[i*DATA_W +: DATA_W] <= in_reg_r[i];
            end
            if (!cs_low) begin
                // a write with update transfers on the select rising edge
                if (cs_rise && pend_r) begin
                    for (i = 0; i < NUM_CH; i = i + 1)
                        if (wr_any_r || ch_r == i[1:0])
                            conv_data[i*DATA_W +: DATA_W] <= in_reg_r[i];
                end
                state_r <= ST_IDLE;
                out_en_r <= 1'b0;
                pend_r <= 1'b0;
                cnt_r <= 4'h0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (sclk_rise && din_s_r[1]) begin
                            hdr_r <= 7'h01;
                            cnt_r <= 4'h1;
                            state_r <= ST_HDR;
                        end
                    end
                    ST_HDR: begin
                        // header ends when the count meets the length for the command seen so far
                        if (sclk_rise) begin
                            hdr_r[cnt_r[2:0]] <= din_s_r[1];
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == hdr_len) begin
                                cnt_r <= 4'h0;
                                ch_r <= is_glob ? 2'h0 : hdr_addr;
                                wr_any_r <= is_glob;
                                if (is_rd)
                                    state_r <= ST_RDATA;
                                else
                                    state_r <= ST_WDATA;
                            end
                        end
                    end
                    ST_WDATA: begin
                        if (sclk_rise) begin
                            shift_r <= {din_s_r[1], shift_r[DATA_W-1:1]};
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == `QDC_DATA_LEN - 4'h1) begin
                                in_reg_r[ch_r] <= {din_s_r[1], shift_r[DATA_W-1:1]};
                                cnt_r <= 4'h0;
                                pend_r <= hdr_r[`QDC_POS_UPD];
                                if (wr_any_r && ch_r != 2'h3)
                                    ch_r <= ch_r + 2'h1; // global: next channel in order
                                else
                                    state_r <= ST_DONE;
                            end
                        end
                    end
                    ST_RDATA: begin
                        // bit index chosen by order flag
                        if (out_edge) begin
                            out_en_r <= 1'b1;
                            serial_out <= msb_first ? rd_word[DATA_W-1-cnt_r[2:0]] : rd_word[cnt_r[2:0]];
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r == `QDC_DATA_LEN - 4'h1) begin
                                cnt_r <= 4'h0;
                                if (wr_any_r && ch_r != 2'h3)
                                    ch_r <= ch_r + 2'h1;
                                else
                                    state_r <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE: begin
                        // last bit stays on the pin until the next output edge
                        if (out_edge)
                            out_en_r <= 1'b0;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // output enable low while driving; released with select high or no readback
    always @* begin
        serial_out_oe_n = ~(out_en_r & cs_low);
    end

    // open drain flag: only ever drives low, pull-up makes the high
    assign power_fail_n_out = 1'b0;
    assign power_fail_n_oe_n = ~pf_r;

endmodule // qdc_ctrl

// [design/qdc_regs.vh]
/*
 * shared constants for the quad converter serial control block:
 * instruction field positions, reset values and frame lengths.
 * assumes inclusion by bare name from the design file.
 */
`ifndef QDC_REGS_VH
`define QDC_REGS_VH

// instruction bit positions, counted from the start bit at position 0
`define QDC_POS_START 0
`define QDC_POS_RDWR 1
`define QDC_POS_GLOBAL 2
`define QDC_POS_UPD 3
`define QDC_POS_RF 3
`define QDC_POS_ML 4

// instruction lengths after the start bit: single write 5 (6 total),
// global write 3 (4 total), read 6 (7 total)
`define QDC_WR_HDR_LEN 4'h5
`define QDC_GW_HDR_LEN 4'h3
`define QDC_RD_HDR_LEN 4'h6
`define QDC_DATA_LEN 4'h8

// reset values
`define QDC_REG_RST 8'h00
`define QDC_PF_RST 1'b1

`endif

// [dv/qdc_ctrl_monitor.sv]
/* port checker for qdc_ctrl.
   assumes pins are async to core_clk and bound to every qdc_ctrl. */
`timescale 1ns/1ps
module qdc_ctrl_monitor #(parameter NUM_CH = 4, parameter DATA_W = 8) (
    input wire core_clk,
    input wire reset,
    input wire serial_clk,
    input wire chip_sel_n,
    input wire async_update_n,
    input wire serial_out,
    input wire serial_out_oe_n,
    input wire power_fail_n_out,
    input wire power_fail_n_oe_n,
    input wire [NUM_CH*DATA_W-1:0] conv_data
);
    reg sck_d_r, cs_d_r, au_d_r;
    reg [3:0] sck_age_r, upd_age_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles since a pin event; saturating so idle time never wraps
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {sck_d_r, cs_d_r, au_d_r} <= 3'h3;
            sck_age_r <= 4'hF;
            upd_age_r <= 4'hF;
        end else begin
            {sck_d_r, cs_d_r, au_d_r} <= {serial_clk, chip_sel_n, async_update_n};
            sck_age_r <= (serial_clk != sck_d_r) ? 4'h0 : sck_age_r + {3'h0, sck_age_r != 4'hF};
            upd_age_r <= ((chip_sel_n & ~cs_d_r) | (au_d_r & ~async_update_n)) ? 4'h0 :
                upd_age_r + {3'h0, upd_age_r != 4'hF};
        end
    end
    pf_open_a: assert property (power_fail_n_out == 1'b0)
        else $error("flag pin data not low");
    pf_keep_a: assert property (!$fell(power_fail_n_oe_n))
        else $error("flag set without reset");
    pf_clear_a: assert property ((!chip_sel_n)[*8] |-> power_fail_n_oe_n)
        else $error("flag not cleared");
    oe_idle_a: assert property ((chip_sel_n)[*6] |-> serial_out_oe_n)
        else $error("output driven while idle");
    oe_start_a: assert property ($fell(serial_out_oe_n) |-> sck_age_r <= 4'hA)
        else $error("output driven without clock");
    dout_edge_a: assert property (!serial_out_oe_n && $changed(serial_out) |-> sck_age_r <= 4'hA)
        else $error("readback moved off clock");
    conv_quiet_a: assert property ((!chip_sel_n)[*8] |-> $stable(conv_data))
        else $error("outputs moved while selected");
    conv_cause_a: assert property ($changed(conv_data) |-> upd_age_r <= 4'hA)
        else $error("outputs moved without cause");
endmodule // qdc_ctrl_monitor
bind qdc_ctrl qdc_ctrl_monitor #(.NUM_CH(NUM_CH), .DATA_W(DATA_W)) qdc_ctrl_monitor_i (.core_clk, .reset,
    .serial_clk, .chip_sel_n, .async_update_n, .serial_out, .serial_out_oe_n, .power_fail_n_out,
    .power_fail_n_oe_n, .conv_data);

// [dv/qdc_host_model.sv]
/* host model driving the three-wire serial port.
   assumes core_clk from the bench; pins move by nba on its rising edge. */
`timescale 1ns/1ps
module qdc_host_model (
    input wire core_clk,
    input wire serial_out,
    input wire serial_out_oe_n,
    output reg serial_clk,
    output reg chip_sel_n,
    output reg serial_in
);
    reg [31:0] rd_r;
    reg rf_r, ml_r, mid_r, mid_ok_r;
    integer n_r, skew_r;
    // serial clock stands low between frames
    initial {serial_clk, chip_sel_n, serial_in} = 3'h2;
    task w(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    // sample just before the edge that moves the next bit, when it is settled;
    // the value seen before the other edge must match, else the bit moved there
    task cap;
        if (!serial_out_oe_n && n_r < 32) begin
            if (mid_ok_r && serial_out !== mid_r)
                skew_r = skew_r + 1;
            rd_r = ml_r ? {rd_r[30:0], serial_out} : {serial_out, rd_r[31:1]};
            n_r = n_r + 1;
        end
    endtask
    task mid;
        mid_r = serial_out;
        mid_ok_r = !serial_out_oe_n;
    endtask
    task tick(input b);
        if (!rf_r) cap;
        if (rf_r) mid;
        serial_clk <= 1'b0;
        serial_in <= b;
        w(6);
        if (rf_r) cap;
        if (!rf_r) mid;
        serial_clk <= 1'b1;
        w(7);
    endtask
    // header from hdr[6] down, then data lsb first, one spare clock, release
    task xfer(input [6:0] hdr, input integer hl, input [31:0] d, input integer db, input rf, input ml);
        integer i;
        rf_r = rf;
        ml_r = ml;
        n_r = 0;
        rd_r = 32'h0;
        skew_r = 0;
        mid_ok_r = 1'b0;
        chip_sel_n <= 1'b0;
        w(6);
        for (i = 0; i < hl; i = i + 1) tick(hdr[6-i]);
        for (i = 0; i < db; i = i + 1) tick(d[i]);
        tick(~serial_in);
        serial_clk <= 1'b0;
        w(6);
        chip_sel_n <= 1'b1;
        serial_in <= ~serial_in;
        w(12);
    endtask
endmodule // qdc_host_model

// [dv/tb.sv]
/* self-checking bench for qdc_ctrl.
   assumes the host model and the bound checker are compiled before it. */
`timescale 1ns/1ps
module tb;
    reg core_clk, reset, async_update_n;
    wire serial_clk, chip_sel_n, serial_in, serial_out, serial_out_oe_n, power_fail_n_out, power_fail_n_oe_n;
    wire [31:0] conv_data;
    wire pf_pin = power_fail_n_oe_n ? 1'b1 : power_fail_n_out; // pull-up when released
    integer err_total, num_checks, cyc, k;
    qdc_ctrl qdc_ctrl_i (.core_clk, .reset, .serial_clk, .chip_sel_n, .serial_in, .async_update_n,
        .serial_out, .serial_out_oe_n, .power_fail_n_out, .power_fail_n_oe_n, .conv_data);
    qdc_host_model qdc_host_model_i (.core_clk, .serial_out, .serial_out_oe_n, .serial_clk, .chip_sel_n,
        .serial_in);
    task chk(input [31:0] got, input [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task wr(input [1:0] ch, input u, input [7:0] d);
        qdc_host_model_i.xfer({3'h4, u, ch, 1'b0}, 6, {24'h0, d}, 8, 1'b0, 1'b0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ceiling far above the few thousand cycles the tests need
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            finish_test;
        end
    end
    initial begin
        reset = 1'b1;
        async_update_n = 1'b1;
        err_total = 0;
        num_checks = 0;
        cyc = 0;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk(conv_data, 32'h0);
        chk(pf_pin, 32'h0);
        wr(2'h2, 1'b1, 8'hA6);
        chk(conv_data, 32'h00A60000);
        chk(pf_pin, 32'h1);
        $display("test write done");
        wr(2'h1, 1'b0, 8'h3C);
        chk(conv_data, 32'h00A60000);
        async_update_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(conv_data, 32'h00A63C00);
        async_update_n <= 1'b1;
        $display("test async done");
        qdc_host_model_i.xfer(7'h58, 4, 32'h44332211, 32, 1'b0, 1'b0);
        chk(conv_data, 32'h44332211);
        $display("test global done");
        for (k = 0; k < 4; k = k + 1) begin
            qdc_host_model_i.xfer({3'h6, k[1], k[0], 2'h2}, 7, 32'h0, 10, k[1], k[0]);
            // lsb-first capture lands in the top byte of the host's word
            chk(qdc_host_model_i.rd_r >> (k[0] ? 0 : 24), 32'h33);
            chk(qdc_host_model_i.skew_r, 32'h0);
            chk(serial_out_oe_n, 32'h1);
        end
        qdc_host_model_i.xfer(7'h72, 7, 32'h0, 32, 1'b0, 1'b0);
        chk(qdc_host_model_i.rd_r, 32'h44332211);
        chk(qdc_host_model_i.skew_r, 32'h0);
        qdc_host_model_i.xfer(7'h7E, 7, 32'h0, 32, 1'b1, 1'b1);
        chk(qdc_host_model_i.rd_r, 32'h11223344);
        chk(qdc_host_model_i.skew_r, 32'h0);
        chk(serial_out_oe_n, 32'h1);
        $display("test read done");
        finish_test;
    end
endmodule // tb
